// ### core/pds_pkg.sv
// Purpose: constants and types of the power domain sequencer
// Assumes: one clock, 40 MHz, async active-low reset
// Notes: mode codes equal the config bit position
// What this block does
// - per-domain, per-mode power config applied
// - one status bit per domain
// - request change only where config bits differ
// - all domains up in reset, then default run
// - default: domains 1 and 2 powered in all modes but standby, domain 0 in all
// - powered-down domain held in reset
// - access to powered-down domain gives error
// - only domain 2 config is writable
// - domains 0 and 1 on outside standby
// - down: clocks off, reset on, disconnect
// - up: connect, wait voltage, clocks, release
// - power-up may abort an unfinished power-down
// - standby: domain 0 on, domain 1 off
// - standby entry powers down cleared domains
// - standby left only by wakeup, to default run
// - wakeup starts power-up of off domains set on for default run
// - default run has domains 0 and 1 powered
// - kept memories retain in standby automatically
// - config bit 1 means on, 0 off
// - status bit 1 operable, 0 inoperable
package pds_pkg;
   localparam int NUM_DOM = 3;
   localparam logic [7:0] OFS_CONF0 = 8'h00;
   localparam logic [7:0] OFS_CONF1 = 8'h04;
   localparam logic [7:0] OFS_CONF2 = 8'h08;
   localparam logic [7:0] OFS_PSTAT = 8'h40;
   // mode codes, also the config bit index
   typedef logic [3:0] pds_mode_t;
   localparam pds_mode_t MODE_RESET = 4'h0;
   localparam pds_mode_t MODE_DEFAULT_RUN_MODE  = 4'h3;
   localparam pds_mode_t MODE_STBY  = 4'hd;
   localparam logic [15:0] MODE_VALID = 16'h25ff;
   localparam logic [15:0] CONF0_RST  = 16'h25ff;
   localparam logic [15:0] CONF1_RST  = 16'h05ff;
   localparam logic [15:0] CONF2_RST  = 16'h05ff;
   localparam logic [2:0]  PSTAT_RST  = 3'h7;
   typedef enum logic [2:0] {
      DS_ON, DS_CLK_OFF, DS_RST_ON, DS_OFF, DS_RAMP, DS_CLK_ON
   } pds_dom_state_t;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pds_bus_req_t;
   typedef struct packed {
      pds_mode_t newMode;
      logic      chg;
      logic      wakeup;
   } pds_mode_req_t;
   typedef struct packed {
      logic [NUM_DOM-1:0] supplyOn;
      logic [NUM_DOM-1:0] clkEn;
      logic [NUM_DOM-1:0] rstOn;
      logic [NUM_DOM-1:0] retain;
   } pds_dom_ctl_t;
endpackage : pds_pkg

// ### core/pds_power_domain_sequencer.sv
// Purpose: per-domain power sequencing by operating mode
// Assumes: mode requests are same-clock logic; voltOk is async
// Notes: domain 0 and 1 configs are constants
//
// The register offsets and the strobed register port were decided locally.
module pds_power_domain_sequencer (
   input  wire logic                   ref_clk,
   input  wire logic                   arst_n,
   input  wire pds_pkg::pds_bus_req_t  busReq,
   output logic [31:0]                 busRdata,
   input  wire pds_pkg::pds_mode_req_t modeReq,
   output pds_pkg::pds_mode_t          curMode,
   input  wire logic [2:0]             voltOk,
   input  wire logic                   periphReq,
   input  wire logic [1:0]             periphDom,
   output logic                        periphErr,
   output pds_pkg::pds_dom_ctl_t       domCtl,
   output logic [2:0]                  domStatus,
   output logic                        seqBusy
);
   import pds_pkg::*;

   // how a domain moves between its states:
   //   on        clocks running, reset released, supply connected
   //   clk-off   clocks stopped; reset is asserted from here on
   //   rst-on    one extra cycle in reset before the supply goes
   //   off       supply disconnected, reset held for as long as it stays here
   //   ramp      supply reconnected, waiting for the synchronised voltage-ok
   //   clk-on    clocks running again, reset still held for one cycle
   // a power-up target met in clk-off or rst-on goes straight to ramp with
   // reset held, so whatever the domain held is lost.
   // a power-down target met in ramp goes straight back to off.
   // targets change only when the operating mode changes, and only for the
   // domains whose config bit differs between the old and the new mode.
   // leaving standby is driven by the wakeup pulse alone; a mode change pulse
   // seen in standby is dropped silently.
   // the busy flag covers both a domain mid-sequence and a domain at rest whose
   // target already points the other way, so that the cycle in which a target
   // moves is not mistaken for a settled state.
   // domain 0 and domain 1 configs are constants; only domain 2 takes writes.

   typedef struct packed {
      pds_mode_t                     mode;
      logic [15:0]                   conf2;
      logic [NUM_DOM-1:0]            tgt;
      pds_dom_state_t [NUM_DOM-1:0]  ds;
      pds_dom_ctl_t                  ctl;
      logic [NUM_DOM-1:0]            stat;
      logic [NUM_DOM-1:0]            vok1;
      logic [NUM_DOM-1:0]            vok2;
      logic [31:0]                   rdata;
   } pds_state_t;

   pds_state_t st_reg;
   pds_state_t st_next;

   // config word of one domain
   function automatic logic [15:0] confOf(input int d, input logic [15:0] c2);
      logic [15:0] r;
      r = c2;
      if (d == 0) begin
         r = CONF0_RST;
      end else if (d == 1) begin
         r = CONF1_RST;
      end
      return r;
   endfunction : confOf

   // power bit of a domain in a mode, 1 = on
   function automatic logic cfgBit(input int d, input logic [15:0] c2,
                                   input pds_mode_t m);
      logic [15:0] w;
      w = confOf(d, c2);
      return w[m];
   endfunction : cfgBit

   // next state of one domain machine
   function automatic pds_dom_state_t stepDom(input pds_dom_state_t s,
                                              input logic t, input logic v);
      pds_dom_state_t n;
      n = s;
      unique case (s)
         DS_ON:      if (!t) n = DS_CLK_OFF;
         DS_CLK_OFF: n = t ? DS_RAMP : DS_RST_ON;
         DS_RST_ON:  n = t ? DS_RAMP : DS_OFF;
         DS_OFF:     if (t) n = DS_RAMP;
         DS_RAMP: begin
            if (!t) begin
               n = DS_OFF;
            end else if (v) begin
               n = DS_CLK_ON;
            end
         end
         DS_CLK_ON:  n = t ? DS_ON : DS_CLK_OFF;
         default:    n = DS_OFF;
      endcase
      return n;
   endfunction : stepDom

   logic anyBusy;
   logic allOn;
   logic newValid;

   // next-state logic
   always_comb begin
      st_next = st_reg;
      st_next.vok1 = voltOk;
      st_next.vok2 = st_reg.vok1;
      newValid = MODE_VALID[modeReq.newMode];
      allOn = 1'b1;
      anyBusy = 1'b0;
      for (int d = 0; d < NUM_DOM; d++) begin
         if (st_reg.ds[d] != DS_ON) allOn = 1'b0;
         if ((st_reg.ds[d] != DS_ON) && (st_reg.ds[d] != DS_OFF)) anyBusy = 1'b1;
         // a domain at rest but aimed the other way has a sequence pending
         if ((st_reg.ds[d] == DS_ON) && !st_reg.tgt[d]) anyBusy = 1'b1;
         if ((st_reg.ds[d] == DS_OFF) && st_reg.tgt[d]) anyBusy = 1'b1;
      end
      // mode change: compare old and new config bits
      if (st_reg.mode == MODE_STBY) begin
         if (modeReq.wakeup) begin
            st_next.mode = MODE_DEFAULT_RUN_MODE;
            for (int d = 0; d < NUM_DOM; d++) begin
               st_next.tgt[d] = cfgBit(d, st_reg.conf2, MODE_DEFAULT_RUN_MODE);
            end
         end
      end else if (modeReq.chg && newValid) begin
         st_next.mode = modeReq.newMode;
         for (int d = 0; d < NUM_DOM; d++) begin
            if (cfgBit(d, st_reg.conf2, modeReq.newMode) !=
                cfgBit(d, st_reg.conf2, st_reg.mode)) begin
               st_next.tgt[d] = cfgBit(d, st_reg.conf2, modeReq.newMode);
            end
         end
      end else if (st_reg.mode == MODE_RESET && allOn) begin
         st_next.mode = MODE_DEFAULT_RUN_MODE;
         for (int d = 0; d < NUM_DOM; d++) begin
            st_next.tgt[d] = cfgBit(d, st_reg.conf2, MODE_DEFAULT_RUN_MODE);
         end
      end
      // domain machines and their registered controls
      for (int d = 0; d < NUM_DOM; d++) begin
         st_next.ds[d] = stepDom(st_reg.ds[d], st_reg.tgt[d], st_reg.vok2[d]);
         st_next.ctl.supplyOn[d] = (st_next.ds[d] != DS_OFF);
         st_next.ctl.clkEn[d] = (st_next.ds[d] == DS_ON) ||
                                (st_next.ds[d] == DS_CLK_ON);
         st_next.ctl.rstOn[d] = (st_next.ds[d] != DS_ON);
         st_next.ctl.retain[d] = (st_next.ds[d] == DS_ON) &&
                                 (st_next.mode == MODE_STBY);
         st_next.stat[d] = (st_next.ds[d] == DS_ON);
      end
      // register writes: only domain 2 config takes them
      if (busReq.wr && busReq.addr == OFS_CONF2) begin
         st_next.conf2 = busReq.wdata[15:0] & MODE_VALID;
      end
      // register reads, data in the next cycle
      st_next.rdata = 32'h0;
      if (busReq.rd) begin
         unique case (busReq.addr)
            OFS_CONF0: st_next.rdata = {16'h0, CONF0_RST};
            OFS_CONF1: st_next.rdata = {16'h0, CONF1_RST};
            OFS_CONF2: st_next.rdata = {16'h0, st_reg.conf2};
            OFS_PSTAT: st_next.rdata = {29'h0, st_reg.stat};
            default:   st_next.rdata = 32'h0;
         endcase
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg.mode <= MODE_RESET;
         st_reg.conf2 <= CONF2_RST;
         st_reg.tgt <= 3'h7;
         st_reg.ds <= '{default: DS_ON};
         st_reg.ctl.supplyOn <= 3'h7;
         st_reg.ctl.clkEn <= 3'h7;
         st_reg.ctl.rstOn <= 3'h0;
         st_reg.ctl.retain <= 3'h0;
         st_reg.stat <= PSTAT_RST;
         st_reg.vok1 <= 3'h0;
         st_reg.vok2 <= 3'h0;
         st_reg.rdata <= 32'h0;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs
   assign busRdata = st_reg.rdata;
   assign curMode = st_reg.mode;
   assign domCtl = st_reg.ctl;
   assign domStatus = st_reg.stat;
   assign seqBusy = anyBusy;
   assign periphErr = periphReq && (periphDom < 2'h3) &&
                      !st_reg.stat[periphDom];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   // checks
   a_conf_fixed_low: assert property (
      busReq.rd && busReq.addr == OFS_CONF1 |=> busRdata == {16'h0, CONF1_RST})
      else $error("domain 1 config not constant");
   a_status_readback: assert property (
      busReq.rd && busReq.addr == OFS_PSTAT |=> busRdata[2:0] == $past(domStatus))
      else $error("status read mismatch");
   a_down_order: assert property (
      $fell(domCtl.supplyOn[2]) |-> $past(domCtl.rstOn[2]) && !$past(domCtl.clkEn[2], 2))
      else $error("power-down order broken");
   a_up_waits_volt: assert property (
      $rose(domCtl.clkEn[2]) && $past(domCtl.rstOn[2]) |-> $past(st_reg.vok2[2]))
      else $error("clocks on before voltage ok");
   a_off_in_reset: assert property (
      ((~domCtl.supplyOn) & (~domCtl.rstOn)) == 3'h0)
      else $error("powered-down domain out of reset");
   a_access_ok: assert property (
      periphReq && periphDom == 2'h2 && !domCtl.rstOn[2] |-> !periphErr)
      else $error("error on powered domain");
   a_core_powered: assert property (
      curMode != MODE_STBY && !seqBusy |-> domCtl.supplyOn[1:0] == 2'h3)
      else $error("core domains off outside standby");
   a_stby_core: assert property (
      curMode == MODE_STBY && !seqBusy ##1 curMode == MODE_STBY
      |-> domCtl.supplyOn[0] && !domCtl.supplyOn[1])
      else $error("standby supply pattern wrong");
   a_stby_exit: assert property (
      curMode == MODE_STBY |=> (curMode == MODE_STBY) != $past(modeReq.wakeup))
      else $error("standby left without wakeup");
   a_retain_stby: assert property (
      domCtl.retain[0] |-> curMode == MODE_STBY ##0 domCtl.supplyOn[0])
      else $error("retention outside standby");
   a_reset_run: assert property (
      $rose(arst_n) |-> ##[1:3] curMode == MODE_DEFAULT_RUN_MODE)
      else $error("default run not reached");

   // register bus checks
   // domain 0 config reads back as its constant
   a_conf0_fixed: assert property (
      busReq.rd && busReq.addr == OFS_CONF0 |=> busRdata == {16'h0, CONF0_RST})
      else $error("domain 0 config not constant");
   // a domain 2 config write lands masked
   a_conf2_write: assert property (
      busReq.wr && busReq.addr == OFS_CONF2 |=> st_reg.conf2 == ($past(busReq.wdata[15:0]) & MODE_VALID))
      else $error("domain 2 config write lost");
   // domain 2 config changes only by its own write
   a_conf2_hold: assert property (
      !(busReq.wr && busReq.addr == OFS_CONF2) |=> $stable(st_reg.conf2))
      else $error("domain 2 config changed without write");
   // no config bit outside the valid modes
   a_conf_bits_valid: assert property (
      (st_reg.conf2 & ~MODE_VALID) == 16'h0)
      else $error("config bit set for unused mode");
   // domain 2 config reads back as stored
   a_conf2_read: assert property (
      busReq.rd && busReq.addr == OFS_CONF2 |=> busRdata == {16'h0, $past(st_reg.conf2)})
      else $error("domain 2 config read mismatch");
   // upper status bits read zero
   a_stat_read_low: assert property (
      busReq.rd && busReq.addr == OFS_PSTAT |=> busRdata[31:3] == 29'h0)
      else $error("status upper bits not zero");
   // unmapped address reads zero
   a_unmapped_read: assert property (
      busReq.rd && busReq.addr == 8'h0c |=> busRdata == 32'h0)
      else $error("unmapped read not zero");

   // mode handling checks
   // a valid change outside standby is taken
   a_mode_follow: assert property (
      curMode != MODE_STBY && modeReq.chg && MODE_VALID[modeReq.newMode]
      |=> curMode == $past(modeReq.newMode))
      else $error("valid mode change not taken");
   // an invalid code leaves the mode alone
   a_bad_mode_ignored: assert property (
      curMode != MODE_STBY && curMode != MODE_RESET && modeReq.chg && !MODE_VALID[modeReq.newMode]
      |=> $stable(curMode))
      else $error("invalid mode code taken");
   // equal config bits leave the target alone
   a_same_cfg_quiet: assert property (
      curMode != MODE_STBY && modeReq.chg && MODE_VALID[modeReq.newMode] &&
      cfgBit(2, st_reg.conf2, modeReq.newMode) == cfgBit(2, st_reg.conf2, curMode)
      |=> st_reg.tgt[2] == $past(st_reg.tgt[2]))
      else $error("target moved without config difference");
   // differing config bits set the new target
   a_diff_cfg_req: assert property (
      curMode != MODE_STBY && modeReq.chg && MODE_VALID[modeReq.newMode] &&
      cfgBit(2, st_reg.conf2, modeReq.newMode) != cfgBit(2, st_reg.conf2, curMode)
      |=> st_reg.tgt[2] == $past(cfgBit(2, st_reg.conf2, modeReq.newMode)))
      else $error("target not moved on config difference");
   // reset mode keeps every domain supplied
   a_reset_all_on: assert property (
      curMode == MODE_RESET |-> domCtl.supplyOn == 3'h7)
      else $error("domain off in reset mode");
   // default run with nothing pending has core domains operable
   a_default_run_mode_core_on: assert property (
      curMode == MODE_DEFAULT_RUN_MODE && !seqBusy |-> domStatus[1:0] == 2'h3)
      else $error("core domains not operable in default run");

   // standby checks
   // entering standby aims domain 1 off
   a_stby_entry_down: assert property (
      curMode != MODE_STBY && modeReq.chg && modeReq.newMode == MODE_STBY |=> !st_reg.tgt[1])
      else $error("domain 1 not aimed off for standby");
   // domain 0 stays supplied in standby
   a_stby_dom0_on: assert property (
      curMode == MODE_STBY |-> domCtl.supplyOn[0])
      else $error("domain 0 off in standby");
   // wakeup leads to default run
   a_stby_wake_mode: assert property (
      curMode == MODE_STBY && modeReq.wakeup |=> curMode == MODE_DEFAULT_RUN_MODE)
      else $error("wakeup did not reach default run");
   // without wakeup standby holds
   a_stby_no_chg: assert property (
      curMode == MODE_STBY && !modeReq.wakeup |=> curMode == MODE_STBY)
      else $error("standby left without wakeup pulse");
   // wakeup aims domain 1 on
   a_wake_target: assert property (
      curMode == MODE_STBY && modeReq.wakeup |=> st_reg.tgt[1])
      else $error("wakeup did not aim domain 1 on");
   // retention only on supplied domains
   a_retain_only_on: assert property (
      (domCtl.retain & ~domCtl.supplyOn) == 3'h0)
      else $error("retention on unsupplied domain");
   // no retention outside standby
   a_retain_zero_run: assert property (
      curMode != MODE_STBY |-> domCtl.retain == 3'h0)
      else $error("retention outside standby");

   // domain sequence checks
   // clocks only with supply
   a_clk_needs_supply: assert property (
      (domCtl.clkEn & ~domCtl.supplyOn) == 3'h0)
      else $error("clock enabled without supply");
   // operable only with clocks
   a_status_needs_clk: assert property (
      (domStatus & ~domCtl.clkEn) == 3'h0)
      else $error("operable without clocks");
   // operable only out of reset
   a_status_out_reset: assert property (
      (domStatus & domCtl.rstOn) == 3'h0)
      else $error("operable while in reset");
   // unsupplied domain never operable
   a_off_no_status: assert property (
      !domCtl.supplyOn[2] |-> !domStatus[2])
      else $error("unsupplied domain reported operable");
   // status follows the on state
   a_stat_is_on: assert property (
      domStatus[2] == (st_reg.ds[2] == DS_ON))
      else $error("status does not follow on state");
   // clocks stop while still supplied
   a_clk_off_first: assert property (
      $fell(domCtl.clkEn[2]) |-> domCtl.supplyOn[2])
      else $error("clocks stopped after disconnect");
   // leaving operable puts reset on and clocks off
   a_status_drop: assert property (
      $fell(domStatus[2]) |-> domCtl.rstOn[2] && !domCtl.clkEn[2])
      else $error("power-down start wrong");
   // reconnect with reset held and clocks off
   a_supply_back: assert property (
      $rose(domCtl.supplyOn[2]) |-> domCtl.rstOn[2] && !domCtl.clkEn[2])
      else $error("reconnect not in reset");
   // ramp holds until voltage is operable
   a_ramp_waits: assert property (
      st_reg.ds[2] == DS_RAMP && st_reg.tgt[2] && !st_reg.vok2[2] |=> st_reg.ds[2] == DS_RAMP)
      else $error("ramp left before voltage ok");
   // clocks come back only with supply
   a_clk_on_supplied: assert property (
      $rose(domCtl.clkEn[2]) |-> domCtl.supplyOn[2])
      else $error("clocks on without supply");
   // reset released after clocks run
   a_rst_release_late: assert property (
      $fell(domCtl.rstOn[2]) |-> $past(domCtl.clkEn[2]))
      else $error("reset released before clocks");
   // becoming operable means clocks on and reset off
   a_up_release: assert property (
      $rose(domStatus[2]) |-> !domCtl.rstOn[2] && domCtl.clkEn[2])
      else $error("operable without release");
   // power-up aborts an unfinished power-down
   a_abort_to_ramp: assert property (
      st_reg.ds[2] == DS_RST_ON && st_reg.tgt[2] |=> st_reg.ds[2] == DS_RAMP)
      else $error("power-down not aborted");
   // access to an inoperable domain is refused
   a_err_off_dom: assert property (
      periphReq && periphDom != 2'h3 && !domStatus[periphDom] |-> periphErr)
      else $error("no error on inoperable domain");

   c_down_done: cover property ($fell(domCtl.supplyOn[2]));
   c_stby_entry: cover property ($rose(curMode == MODE_STBY));
   c_abort_down: cover property (st_reg.ds[2] == DS_CLK_OFF ##1 st_reg.ds[2] == DS_RAMP);
   c_wake: cover property (curMode == MODE_STBY && modeReq.wakeup);
endmodule : pds_power_domain_sequencer

// ### testbench/pds_mode_entry_model.sv
// Purpose: mode entry controller and supply monitor model
// Assumes: same clock as the sequencer
// Notes: rampLen sets how slowly a connected supply rises
module pds_mode_entry_model (
   input  wire logic              ref_clk,
   input  wire logic [2:0]        supplyOn,
   output pds_pkg::pds_mode_req_t modeReq,
   output logic [2:0]             voltOk
);
   timeunit 1ns;
   timeprecision 100ps;
   import pds_pkg::*;
   int rampLen = 0;
   int rampCnt [3] = '{0, 0, 0};
   initial modeReq = '0;
   initial voltOk = 3'h0;
   // voltage rises rampLen+1 cycles after connect, drops one cycle after disconnect
   always @(posedge ref_clk) begin
      for (int i = 0; i < 3; i++) begin
         rampCnt[i] <= supplyOn[i] ? rampCnt[i] + 1 : 0;
         voltOk[i]  <= supplyOn[i] && rampCnt[i] >= rampLen;
      end
   end
   // one-cycle request pulse; the mode code wanders while idle
   task automatic request(input pds_mode_t m, input logic wake);
      @(posedge ref_clk);
      modeReq <= '{newMode: m, chg: !wake, wakeup: wake};
      @(posedge ref_clk);
      modeReq <= '{newMode: m + 4'h5, chg: 1'b0, wakeup: 1'b0};
   endtask : request
endmodule : pds_mode_entry_model

// ### testbench/test_power_domain_sequencer.sv
// Purpose: self-checking bench of the power domain sequencer
// Assumes: 40 MHz clock, reset held two cycles
// Notes: read results go through a queue of expected words
module test_power_domain_sequencer;
   timeunit 1ns;
   timeprecision 100ps;
   import pds_pkg::*;
   logic          ref_clk = 1'b0;
   logic          arst_n = 1'b0;
   pds_bus_req_t  busReq = '0;
   logic [31:0]   busRdata;
   pds_mode_req_t modeReq;
   pds_mode_t     curMode;
   logic [2:0]    voltOk, domStatus;
   logic          periphReq = 1'b0, periphErr, seqBusy, rdSeen = 1'b0;
   logic [1:0]    periphDom = 2'h0;
   pds_dom_ctl_t  domCtl;
   logic [31:0]   expQ [$];
   logic [31:0]   rnd;
   logic [15:0]   conf2 = 16'h04df;
   int            mismatches = 0, checkCount = 0, seed = 9567;
   logic [7:0]    regAddr [5] = '{OFS_CONF0, OFS_CONF1, OFS_CONF2, OFS_PSTAT, 8'h0c};
   logic [31:0]   regExp [5] = '{{16'h0, CONF0_RST}, {16'h0, CONF1_RST}, {16'h0, CONF2_RST}, 32'h7, 32'h0};
   pds_mode_t     modes [8] = '{4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'h3};

   pds_power_domain_sequencer u_pds_power_domain_sequencer (.ref_clk(ref_clk), .arst_n(arst_n),
      .busReq(busReq), .busRdata(busRdata), .modeReq(modeReq), .curMode(curMode), .voltOk(voltOk),
      .periphReq(periphReq), .periphDom(periphDom), .periphErr(periphErr), .domCtl(domCtl),
      .domStatus(domStatus), .seqBusy(seqBusy));
   pds_mode_entry_model u_pds_mode_entry_model (.ref_clk(ref_clk), .supplyOn(domCtl.supplyOn),
      .modeReq(modeReq), .voltOk(voltOk));

   // clock
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checkCount++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", checkCount, mismatches);
      if (mismatches == 0 && checkCount > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : giveVerdict

   task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      busReq.wr <= 1'b0;
   endtask : busWrite

   task automatic busRead(input logic [7:0] a, input logic [31:0] exp);
      expQ.push_back(exp);
      @(posedge ref_clk);
      busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      busReq.rd <= 1'b0;
   endtask : busRead

   task automatic setMode(input pds_mode_t m, input logic wake, input pds_mode_t exp);
      u_pds_mode_entry_model.request(m, wake);
      @(negedge ref_clk);
      check("mode", exp, curMode);
   endtask : setMode

   // bounded wait for a status pattern; running out ends the run
   task automatic waitStatus(input logic [2:0] exp);
      repeat (80) if (domStatus !== exp) @(negedge ref_clk);
      check("domain status", exp, domStatus);
      if (domStatus !== exp) giveVerdict();
   endtask : waitStatus

   // read data stand one cycle after the strobe, zero otherwise; domain invariants
   always @(negedge ref_clk) begin
      if (rdSeen) check("read data", expQ.pop_front(), busRdata);
      else check("idle read data", 32'h0, busRdata);
      rdSeen = busReq.rd;
      for (int i = 0; i < 3; i++) begin
         if (arst_n && !domCtl.supplyOn[i]) check("off held", 2'b01, {domCtl.clkEn[i], domCtl.rstOn[i]});
         if (arst_n && domStatus[i]) check("on state", 3'b101, {domCtl.clkEn[i], domCtl.rstOn[i], voltOk[i]});
      end
   end

   // main sequence
   initial begin
      repeat (2) @(negedge ref_clk);
      check("reset mode", MODE_RESET, curMode);
      check("reset controls", 12'hfc0, domCtl);
      @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (2) @(negedge ref_clk);
      check("run after reset", {MODE_DEFAULT_RUN_MODE, 3'h7}, {curMode, domStatus});
      busWrite(OFS_CONF0, 32'h0);
      busWrite(OFS_CONF1, 32'h0);
      busWrite(OFS_PSTAT, 32'h0);
      foreach (regAddr[i]) busRead(regAddr[i], regExp[i]);
      repeat (4) begin
         rnd = $random(seed) | 32'h8;
         busWrite(OFS_CONF2, rnd);
         busRead(OFS_CONF2, rnd & {16'h0, MODE_VALID});
      end
      busWrite(OFS_CONF2, {16'h0, conf2});
      setMode(4'h1, 1'b0, 4'h1);
      repeat (3) @(negedge ref_clk);
      check("quiet", {1'b0, 12'hfc0}, {seqBusy, domCtl});
      setMode(4'hb, 1'b0, 4'h1);
      foreach (modes[i]) begin
         setMode(modes[i], 1'b0, modes[i]);
         waitStatus({conf2[modes[i]], 2'b11});
      end
      setMode(4'h8, 1'b0, 4'h8);
      waitStatus(3'b011);
      @(posedge ref_clk) periphReq <= 1'b1;
      periphDom <= 2'h2;
      @(negedge ref_clk) check("access error", 1'b1, periphErr);
      @(posedge ref_clk) periphDom <= 2'h1;
      @(negedge ref_clk) check("access ok", 1'b0, periphErr);
      @(posedge ref_clk) periphReq <= 1'b0;
      u_pds_mode_entry_model.rampLen = 6;
      setMode(4'h3, 1'b0, 4'h3);
      waitStatus(3'h7);
      setMode(4'h8, 1'b0, 4'h8);
      setMode(4'h4, 1'b0, 4'h4);
      waitStatus(3'h7);
      setMode(MODE_STBY, 1'b0, MODE_STBY);
      waitStatus(3'b001);
      repeat (3) @(negedge ref_clk);
      check("standby ctl", 6'b001001, {domCtl.supplyOn, domCtl.retain});
      setMode(MODE_DEFAULT_RUN_MODE, 1'b0, MODE_STBY);
      setMode(4'h0, 1'b1, MODE_DEFAULT_RUN_MODE);
      waitStatus(3'h7);
      giveVerdict();
   end
endmodule : test_power_domain_sequencer
